// [hdl/uhr_apply_timer.sv]
`timescale 1ns/1ns
// ****************************************************************
// Commit delay: one done pulse a fixed count after start
// ****************************************************************
module uhr_apply_timer
  import uhr_pkg::*;
#(
  parameter int CYCLES = APPLY_CYCLES      // Cycles the hardware needs to take a set
) (
  input wire logic sys_clk,                // System clock
  input wire logic rst,                    // Synchronous reset, active high
  input wire logic start,                  // Begin a commit
  output logic done                        // One-cycle pulse, commit may finish
);

  localparam int CW = $clog2(CYCLES + 1);  // Counter width
  localparam logic [CW-1:0] LOAD = CW'(CYCLES); // Reload value

  logic [CW-1:0] count;                    // Cycles still to wait

  // Count down; a new start simply reloads
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= LOAD;
      end else if (count != '0) begin
        count <= count - 1'b1;
        if (count == CW'(1)) begin
          done <= 1'b1;
        end
      end
    end
  end

endmodule : uhr_apply_timer

// [hdl/uhr_pkg.sv]
// ****************************************************************
// Shared constants for the one-way hot reconfiguration block
// ****************************************************************
package uhr_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int LANES = 8;                  // Lanes in the data path
  localparam int EQW = 4;                    // Equalizer bits per lane
  localparam int SELW = 4;                   // Application selector code width

  // ****************************************************************
  // Register byte offsets (one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0] OFS_CAPS = 8'h00;   // Capabilities, read only
  localparam logic [7:0] OFS_STG0_CFG = 8'h04; // Staged set 0 selector, lanes, path kind
  localparam logic [7:0] OFS_STG0_EQ = 8'h08;  // Staged set 0 per-lane equalizer
  localparam logic [7:0] OFS_STG1_CFG = 8'h0c; // Staged set 1 selector, lanes, path kind
  localparam logic [7:0] OFS_STG1_EQ = 8'h10;  // Staged set 1 per-lane equalizer
  localparam logic [7:0] OFS_TRIG0 = 8'h14;  // Apply triggers of staged set 0
  localparam logic [7:0] OFS_TRIG1 = 8'h18;  // Apply triggers of staged set 1
  localparam logic [7:0] OFS_STATUS = 8'h1c; // Command status
  localparam logic [7:0] OFS_COMMITTED = 8'h20; // Traditional committed control set
  localparam logic [7:0] OFS_CFG_TX = 8'h24; // Committed transmit record
  localparam logic [7:0] OFS_CFG_RX = 8'h28; // Committed receive record
  localparam logic [7:0] OFS_EQ_TX = 8'h2c;  // Committed transmit equalizer
  localparam logic [7:0] OFS_EQ_RX = 8'h30;  // Committed receive equalizer
  localparam logic [7:0] OFS_PATH = 8'h34;   // Current data path state, read only

  // ****************************************************************
  // Field positions and masks
  // ****************************************************************
  localparam int CAP_ONEWAY_BIT = 0;         // one_way_reconfig_capable
  localparam int CAP_SET2_BIT = 1;           // Second staged set present
  localparam int CFG_SEL_LSB = 0;            // Selector code field
  localparam int CFG_LANE_LSB = 8;           // Lane allocation field
  localparam int CFG_NETPATH_BIT = 16;       // Set targets a network_path application
  localparam logic [31:0] CFG_MASK = 32'h0001_ff0f; // Writable configuration bits
  localparam logic [31:0] SEL_MASK = 32'h0000_000f; // Selector bits only
  localparam int TRIG_BOTH_BIT = 0;          // instant_apply_both
  localparam int TRIG_TX_BIT = 1;            // transmit_only_instant_apply
  localparam int TRIG_RX_BIT = 2;            // receive_only_instant_apply

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [1:0] ST_IDLE = 2'h0;     // No command yet
  localparam logic [1:0] ST_BUSY = 2'h1;     // Command in progress
  localparam logic [1:0] ST_OK = 2'h2;       // Command succeeded
  localparam logic [1:0] ST_FAIL = 2'h3;     // Command rejected
  localparam logic [2:0] PATH_READY_IDLE = 3'h2; // path_ready_idle code
  localparam logic [2:0] PATH_RUNNING = 3'h4;    // path_running code
  localparam logic [31:0] CFG_RESET = 32'h0000_0000; // Reset of every config record
  localparam logic [31:0] EQ_RESET = 32'h0000_0000;  // Reset of every equalizer record

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;         // sys_clk period
  localparam int APPLY_TIME_NS = 40;         // Least time to commit a set to hardware
  localparam int APPLY_CYCLES = (APPLY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {DIR_NONE, DIR_BOTH, DIR_TX, DIR_RX} uhr_dir_e; // Apply direction
  typedef enum logic {S_IDLE, S_APPLY} uhr_state_e; // Command sequencer

endpackage : uhr_pkg

// [hdl/uhr_reconfig.sv]
`timescale 1ns/1ns
// Summary of operation
// - Capability bit reports one-way reconfiguration support
// - Second staged set advertised by separate bit
// - Fast reconfiguration switches between two staged sets
// - Both-direction instant apply accepted in any path state while no command runs
// - Transmit-only/receive-only apply touches one direction
// - One-way triggers act only in steady states
// - Other states: one-way triggers silently dropped
// - Entering ready-idle from a non-steady state makes both directions equal unless a one-way commit lands in the same cycle
// - One-way change alters selector, same on all lanes
// - One-way change may alter per-lane equalizers
// - One-way change never alters lane allocation
// - No one-way change for network path applications
// - Set chosen by which trigger register written
// - Status shows busy, success or failure
// - Failed validation changes no committed record or output
// - Separate committed transmit and receive records
// - Traditional committed set mirrors transmit record
// - Without one-way use both records match
module uhr_reconfig
  import uhr_pkg::*;
#(
  parameter bit ONE_WAY_CAPABLE = 1'b1,    // one_way_reconfig_capable
  parameter bit SECOND_SET = 1'b1,         // Staged set 1 is present
  parameter int NLANES = LANES             // Lanes in the data path
) (
  input wire logic sys_clk,                // System clock, 100 MHz
  input wire logic rst,                    // Synchronous reset, active high
  input wire logic [7:0] avs_address,      // Avalon byte address
  input wire logic avs_read,               // Avalon read request
  input wire logic avs_write,              // Avalon write request
  input wire logic [31:0] avs_writedata,   // Avalon write data
  output logic [31:0] avs_readdata,        // Avalon read data
  output logic avs_waitrequest,            // Avalon wait request
  input wire logic [2:0] pathState,        // data_path_state_machine state, same clock
  output logic [SELW-1:0] hwSelTx,         // Applied transmit selector code
  output logic [SELW-1:0] hwSelRx,         // Applied receive selector code
  output logic [NLANES-1:0] hwLanes,       // Applied lane allocation
  output logic [NLANES*EQW-1:0] hwEqTx,    // Applied transmit equalizers
  output logic [NLANES*EQW-1:0] hwEqRx,    // Applied receive equalizers
  output logic hwCommit                    // One-cycle pulse when a command commits to hardware
);

  localparam int EQBITS = NLANES * EQW;    // Equalizer record width
  localparam int APPLY_WAIT = APPLY_CYCLES + 2; // Trigger to final status

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  uhr_state_e state;                       // Command sequencer state
  uhr_dir_e cmdDir;                        // Direction of running command
  uhr_dir_e trigDir;                       // Direction decoded from a trigger write
  logic [31:0] stg0Cfg;                    // Staged set 0 configuration
  logic [31:0] stg1Cfg;                    // Staged set 1 configuration
  logic [EQBITS-1:0] stg0Eq;               // Staged set 0 equalizers
  logic [EQBITS-1:0] stg1Eq;               // Staged set 1 equalizers
  logic [31:0] cfgTx;                      // Committed transmit record
  logic [31:0] cfgRx;                      // Committed receive record
  logic [EQBITS-1:0] eqTx;                 // Committed transmit equalizers
  logic [EQBITS-1:0] eqRx;                 // Committed receive equalizers
  logic [31:0] cmdCfg;                     // Snapshot of the chosen set
  logic [EQBITS-1:0] cmdEq;                // Snapshot of the chosen equalizers
  logic cmdOk;                             // Snapshot passed validation
  logic [1:0] cmdStatus;                   // Command status code
  logic [2:0] prevPath;                    // Path state one cycle ago
  logic oneWayUsed;                        // A one-way change is in force
  logic wrEn;                              // Write taken this edge
  logic trigHit;                           // Write to an enabled trigger register
  logic useSet1;                           // Trigger belongs to set 1
  logic oneWayTrig;                        // Trigger asks for one direction
  logic startCmd;                          // Trigger accepted
  logic validOk;                           // Validator verdict on the chosen set
  logic timerDone;                         // Commit delay elapsed
  logic finishCmd;                         // Command ends this edge
  logic enterIdle;                         // Path newly entered ready-idle

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Steady states in which one-way triggers count
  function automatic logic isSteady(input logic [2:0] st);
    isSteady = (st == PATH_READY_IDLE) || (st == PATH_RUNNING);
  endfunction : isSteady

  // Several trigger bits at once: both wins, then transmit, then receive
  function automatic uhr_dir_e decodeTrig(input logic [31:0] d);
    if (d[TRIG_BOTH_BIT]) begin
      decodeTrig = DIR_BOTH;
    end else if (d[TRIG_TX_BIT]) begin
      decodeTrig = DIR_TX;
    end else if (d[TRIG_RX_BIT]) begin
      decodeTrig = DIR_RX;
    end else begin
      decodeTrig = DIR_NONE;
    end
  endfunction : decodeTrig

  // ****************************************************************
  // Avalon slave: one wait cycle, then answer
  // ****************************************************************
  assign wrEn = avs_write && !avs_waitrequest;

  // Waitrequest drops for exactly one cycle per request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_waitrequest && (avs_read || avs_write)) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data is prepared while waitrequest is still high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        OFS_CAPS: avs_readdata <= 32'({SECOND_SET, ONE_WAY_CAPABLE});
        OFS_STG0_CFG: avs_readdata <= stg0Cfg;
        OFS_STG0_EQ: avs_readdata <= 32'(stg0Eq);
        OFS_STG1_CFG: avs_readdata <= stg1Cfg;
        OFS_STG1_EQ: avs_readdata <= 32'(stg1Eq);
        OFS_STATUS: avs_readdata <= 32'(cmdStatus);
        OFS_COMMITTED: avs_readdata <= cfgTx;
        OFS_CFG_TX: avs_readdata <= cfgTx;
        OFS_CFG_RX: avs_readdata <= cfgRx;
        OFS_EQ_TX: avs_readdata <= 32'(eqTx);
        OFS_EQ_RX: avs_readdata <= 32'(eqRx);
        OFS_PATH: avs_readdata <= 32'(pathState);
        // Unmapped and trigger offsets read as zero
        default: avs_readdata <= '0;
      endcase
    end
  end

  // ****************************************************************
  // Staged sets
  // ****************************************************************
  // Host prepares both sets ahead; set 1 stays zero when absent
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stg0Cfg <= CFG_RESET;
      stg0Eq <= EQ_RESET;
      stg1Cfg <= CFG_RESET;
      stg1Eq <= EQ_RESET;
    end else if (wrEn) begin
      if (avs_address == OFS_STG0_CFG) begin
        stg0Cfg <= avs_writedata & CFG_MASK;
      end
      if (avs_address == OFS_STG0_EQ) begin
        stg0Eq <= avs_writedata[EQBITS-1:0];
      end
      if (SECOND_SET && avs_address == OFS_STG1_CFG) begin
        stg1Cfg <= avs_writedata & CFG_MASK;
      end
      if (SECOND_SET && avs_address == OFS_STG1_EQ) begin
        stg1Eq <= avs_writedata[EQBITS-1:0];
      end
    end
  end

  // ****************************************************************
  // Trigger acceptance
  // ****************************************************************
  assign useSet1 = SECOND_SET && (avs_address == OFS_TRIG1);
  assign trigHit = wrEn && ((avs_address == OFS_TRIG0) || useSet1);
  assign trigDir = decodeTrig(avs_writedata);
  assign oneWayTrig = (trigDir == DIR_TX) || (trigDir == DIR_RX);

  // A trigger during a running command is dropped; the host is meant to wait
  assign startCmd = trigHit && (trigDir != DIR_NONE) && (state == S_IDLE)
    && (!oneWayTrig
      || (ONE_WAY_CAPABLE && isSteady(pathState)));

  // Parameters are checked on the set as it stands at the trigger
  uhr_validator #(
    .NLANES(NLANES)
  ) u_validator (
    .dir(trigDir),
    .cfg(useSet1 ? stg1Cfg : stg0Cfg),
    .heldLanes(cfgTx[CFG_LANE_LSB +: NLANES]),
    .ok(validOk)
  );

  // The commit waits the time the hardware needs to take the set
  uhr_apply_timer #(
    .CYCLES(APPLY_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(startCmd),
    .done(timerDone)
  );

  assign finishCmd = (state == S_APPLY) && timerDone;

  // ****************************************************************
  // Command sequencer and status
  // ****************************************************************
  // Snapshot freezes the set so later host writes cannot tear it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= S_IDLE;
      cmdDir <= DIR_NONE;
      cmdCfg <= CFG_RESET;
      cmdEq <= EQ_RESET;
      cmdOk <= 1'b0;
      cmdStatus <= ST_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (startCmd) begin
            state <= S_APPLY;
            cmdDir <= trigDir;
            cmdCfg <= useSet1 ? stg1Cfg : stg0Cfg;
            cmdEq <= useSet1 ? stg1Eq : stg0Eq;
            cmdOk <= validOk;
            cmdStatus <= ST_BUSY;
          end
        end
        S_APPLY: begin
          if (timerDone) begin
            state <= S_IDLE;
            cmdStatus <= cmdOk ? ST_OK : ST_FAIL;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Committed records and hardware outputs
  // ****************************************************************
  assign enterIdle = (pathState == PATH_READY_IDLE) && !isSteady(prevPath);

  // Path state history for entry detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prevPath <= '0;
    end else begin
      prevPath <= pathState;
    end
  end

  // A commit wins over the symmetry copy when both fall in one cycle; the copy is then lost
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfgTx <= CFG_RESET;
      cfgRx <= CFG_RESET;
      eqTx <= EQ_RESET;
      eqRx <= EQ_RESET;
      oneWayUsed <= 1'b0;
    end else if (finishCmd && cmdOk) begin
      unique case (cmdDir)
        DIR_TX: begin
          cfgTx <= (cfgTx & ~SEL_MASK) | (cmdCfg & SEL_MASK);
          eqTx <= cmdEq;
          oneWayUsed <= 1'b1;
        end
        DIR_RX: begin
          cfgRx <= (cfgRx & ~SEL_MASK) | (cmdCfg & SEL_MASK);
          eqRx <= cmdEq;
          oneWayUsed <= 1'b1;
        end
        default: begin
          cfgTx <= cmdCfg;
          cfgRx <= cmdCfg;
          eqTx <= cmdEq;
          eqRx <= cmdEq;
          oneWayUsed <= 1'b0;
        end
      endcase
    end else if (enterIdle) begin
      cfgRx <= cfgTx;
      eqRx <= eqTx;
      oneWayUsed <= 1'b0;
    end
  end

  assign hwSelTx = cfgTx[CFG_SEL_LSB +: SELW];
  assign hwSelRx = cfgRx[CFG_SEL_LSB +: SELW];
  assign hwLanes = cfgTx[CFG_LANE_LSB +: NLANES];
  assign hwEqTx = eqTx;
  assign hwEqRx = eqRx;

  // Pulse marks the edge where the outputs took a new set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hwCommit <= 1'b0;
    end else begin
      hwCommit <= finishCmd && cmdOk;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_caps;
    avs_read && avs_waitrequest && avs_address == OFS_CAPS
      |=> avs_readdata[CAP_ONEWAY_BIT] == ONE_WAY_CAPABLE && avs_readdata[CAP_SET2_BIT] == SECOND_SET;
  endproperty
  a_caps: assert property (p_caps) else $error("capability bits wrong");

  property p_drop;
    trigHit && oneWayTrig && !isSteady(pathState) && state == S_IDLE
      |=> state == S_IDLE && cmdStatus == $past(cmdStatus);
  endproperty
  a_drop: assert property (p_drop) else $error("one-way trigger outside steady state acted");

  property p_finish;
    startCmd |=> cmdStatus == ST_BUSY ##[1:APPLY_WAIT] (cmdStatus == ST_OK || cmdStatus == ST_FAIL);
  endproperty
  a_finish: assert property (p_finish) else $error("command status did not complete");

  property p_fail;
    finishCmd && !cmdOk |=> cfgTx == $past(cfgTx) && cfgRx == $past(cfgRx) && !hwCommit;
  endproperty
  a_fail: assert property (p_fail) else $error("rejected command changed state");

  property p_tx_only;
    finishCmd && cmdOk && cmdDir == DIR_TX |=> cfgRx == $past(cfgRx) && eqRx == $past(eqRx);
  endproperty
  a_tx_only: assert property (p_tx_only) else $error("transmit-only touched receive");

  property p_rx_only;
    finishCmd && cmdOk && cmdDir == DIR_RX |=> cfgTx == $past(cfgTx) && eqTx == $past(eqTx) && hwCommit;
  endproperty
  a_rx_only: assert property (p_rx_only) else $error("receive-only touched transmit");

  property p_lanes;
    finishCmd && cmdOk && cmdDir != DIR_BOTH |=> hwLanes == $past(hwLanes);
  endproperty
  a_lanes: assert property (p_lanes) else $error("one-way change moved lanes");

  property p_symmetric;
    !oneWayUsed |-> cfgTx == cfgRx && eqTx == eqRx;
  endproperty
  a_symmetric: assert property (p_symmetric) else $error("records differ without one-way use");

  property p_capable;
    state == S_APPLY |-> ONE_WAY_CAPABLE || cmdDir == DIR_BOTH;
  endproperty
  a_capable: assert property (p_capable) else $error("one-way command ran while not capable");

endmodule : uhr_reconfig

// [hdl/uhr_validator.sv]
`timescale 1ns/1ns
// ****************************************************************
// Parameter check of a staged set against the command direction
// ****************************************************************
module uhr_validator
  import uhr_pkg::*;
#(
  parameter int NLANES = LANES             // Lanes in the data path
) (
  input wire uhr_dir_e dir,                // Requested direction
  input wire logic [31:0] cfg,             // Staged configuration word
  input wire logic [NLANES-1:0] heldLanes, // Currently committed lane allocation
  output logic ok                          // Set may be committed
);

  logic [SELW-1:0] sel;                    // Staged selector code
  logic [NLANES-1:0] lanes;                // Staged lane allocation
  logic oneWay;                            // Direction-restricted command

  assign sel = cfg[CFG_SEL_LSB +: SELW];
  assign lanes = cfg[CFG_LANE_LSB +: NLANES];
  assign oneWay = (dir == DIR_TX) || (dir == DIR_RX);

  // ****************************************************************
  // Decision
  // ****************************************************************
  // Selector zero and an empty lane set never name a usable application
  always_comb begin
    ok = (sel != '0) && (lanes != '0) && (dir != DIR_NONE);
    if (oneWay) begin
      // A one-way change keeps the lane allocation
      ok = ok && (lanes == heldLanes);
      // Network path applications are never changed one way
      ok = ok && !cfg[CFG_NETPATH_BIT];
    end
  end

endmodule : uhr_validator

// [verification/tb.sv]
`timescale 1ns/1ns
// ****************************************************************
// Bench: random staged sets in steady and transient path states
// ****************************************************************
module tb;
  import uhr_pkg::*;
  logic sys_clk = 1'b0;         // 100 MHz clock
  logic rst = 1'b1;             // Held for 20 cycles
  logic [2:0] pathState = 3'h1; // Starts in a transient state
  logic [7:0] avs_address, hwLanes;
  logic avs_read, avs_write, avs_waitrequest, hwCommit;
  logic [31:0] avs_writedata, avs_readdata, q, tx, rx, etx, erx, s, e, hwEqTx, hwEqRx;
  logic [3:0] hwSelTx, hwSelRx;
  logic [31:0] t0, rd2;         // First both-direction set, read data of the copy
  logic [3:0] selTx2, selRx2;   // Applied selectors of the copy
  logic hc2;                    // Commit pulse of the copy
  int nCommit = 0;
  int nCommit2 = 0;
  int nFail = 0;
  int checked = 0;
  always #5 sys_clk = ~sys_clk;
  uhr_reconfig i_uhr_reconfig(.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .pathState, .hwSelTx, .hwSelRx, .hwLanes, .hwEqTx, .hwEqRx, .hwCommit);
  uhr_host_model i_uhr_host_model(.sys_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest);
  // Copy without one-way support sees the same traffic; its bus answer runs in lockstep
  uhr_reconfig #(.ONE_WAY_CAPABLE(1'b0)) i_uhr_reconfig_nocap(.sys_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata(rd2), .avs_waitrequest(), .pathState, .hwSelTx(selTx2),
    .hwSelRx(selRx2), .hwLanes(), .hwEqTx(), .hwEqRx(), .hwCommit(hc2));
  // Count commit pulses; a stuck or missing pulse shows in the totals
  always @(posedge sys_clk) begin
    nCommit += int'(hwCommit === 1'b1);
    nCommit2 += int'(hc2 === 1'b1);
  end
  // Expected word of a staged set
  function automatic logic [31:0] cfgw(input logic [3:0] sel, input logic [7:0] ln, input logic np);
    return {15'h0, np, ln, 4'h0, sel};
  endfunction : cfgw
  // One-way change keeps everything but the selector
  function automatic logic [31:0] oneway(input logic [31:0] old, input logic [31:0] nw);
    return (old & ~SEL_MASK) | (nw & SEL_MASK);
  endfunction : oneway
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a);
    i_uhr_host_model.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  // Compare every committed record and the applied outputs
  task automatic recs();
    rd(OFS_CFG_TX); chk("cfg_tx", q, tx);
    rd(OFS_CFG_RX); chk("cfg_rx", q, rx);
    rd(OFS_COMMITTED); chk("committed", q, tx);
    rd(OFS_EQ_TX); chk("eq_tx", q, etx);
    rd(OFS_EQ_RX); chk("eq_rx", q, erx);
    chk("hw_eq_tx", hwEqTx, etx);
    chk("hw_eq_rx", hwEqRx, erx);
    chk("hw_sel", {24'h0, hwSelTx, hwSelRx}, {24'h0, tx[3:0], rx[3:0]});
    chk("hw_lanes", {24'h0, hwLanes}, {24'h0, tx[15:8]});
  endtask : recs
  task automatic tally_and_finish();
    if (nFail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    nFail++;
    tally_and_finish();
  end
  initial begin
    q = $urandom(32'h0923);
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFS_CAPS); chk("caps", q, 32'h3);
    chk("caps_nocap", rd2, 32'h2);
    rd(8'h3c); chk("unmapped", q, 32'h0);
    // Both directions accepted even in a transient state
    tx = cfgw(4'($urandom_range(15, 1)), 8'hff, 1'b0);
    t0 = tx;
    etx = $urandom;
    rx = tx;
    erx = etx;
    i_uhr_host_model.xfer(1'b1, OFS_STG0_CFG, tx, q);
    i_uhr_host_model.xfer(1'b1, OFS_STG0_EQ, etx, q);
    i_uhr_host_model.cmd(OFS_TRIG0, 32'h1, q); chk("st_both", q, ST_OK);
    recs();
    // One-way: good sets, then network path flag, then lane change
    for (int k = 0; k < 8; k++) begin
      pathState <= k[1] ? PATH_READY_IDLE : PATH_RUNNING;
      s = cfgw(4'($urandom_range(15, 1)), k > 5 ? 8'h0f : 8'hff, k == 4 || k == 5);
      e = $urandom;
      i_uhr_host_model.xfer(1'b1, OFS_STG1_CFG, s, q);
      i_uhr_host_model.xfer(1'b1, OFS_STG1_EQ, e, q);
      i_uhr_host_model.cmd(OFS_TRIG1, k[0] ? 32'h4 : 32'h2, q);
      chk("st_one", q, k > 3 ? ST_FAIL : ST_OK);
      if (k < 4 && k[0]) begin
        rx = oneway(rx, s);
        erx = e;
      end else if (k < 4) begin
        tx = oneway(tx, s);
        etx = e;
      end
      recs();
    end
    // Transient state: trigger dropped, status keeps the last failure
    pathState <= 3'h5;
    i_uhr_host_model.cmd(OFS_TRIG1, 32'h4, q); chk("st_drop", q, ST_FAIL);
    recs();
    // Entry to ready-idle makes the receive side match the transmit side
    pathState <= PATH_READY_IDLE;
    rx = tx;
    erx = etx;
    recs();
    chk("commits", nCommit, 5);
    chk("commits_nocap", nCommit2, 1);
    chk("nocap_sel", {24'h0, selTx2, selRx2}, {24'h0, t0[3:0], t0[3:0]});
    tally_and_finish();
  end
endmodule : tb

// [verification/uhr_host_model.sv]
`timescale 1ns/1ns
// ****************************************************************
// Host model: management master on the Avalon side
// ****************************************************************
module uhr_host_model
  import uhr_pkg::*;
(
  input wire logic sys_clk,             // System clock
  output logic [7:0] avs_address,       // Byte address
  output logic avs_read,                // Read request
  output logic avs_write,               // Write request
  output logic [31:0] avs_writedata,    // Write data
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest      // Slave stall
);
  initial {avs_address, avs_read, avs_write, avs_writedata} = '0;
  // Request held until waitrequest is sampled low, data taken at that edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : xfer
  // Fire a trigger, then poll so no path state change overlaps the command
  task automatic cmd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] st);
    xfer(1'b1, a, d, st);
    do xfer(1'b0, OFS_STATUS, 32'h0, st); while (st[1:0] === ST_BUSY);
  endtask : cmd
endmodule : uhr_host_model
